// file: hdl/config_mode_pin_decode.v
// Decodes the mode pin and the two shared configuration pins.
`timescale 1ns/1ps
`include "config_mode_pin_regs.vh"
module config_mode_pin_decode #(
  parameter [3:0] SETTLE = `SETTLE_COUNT
) (
  input wire sys_clk,
  input wire reset,
  input wire [1:0] mode_pin_level,
  input wire code_bus_pin,
  input wire [1:0] ja_cs_pin_level,
  input wire e1_select,
  input wire unipolar_select,
  input wire host_code_bit,
  input wire serial_access_req,
  input wire parallel_access_req,
  output wire [2:0] op_mode,
  output wire parallel_if_enable,
  output wire serial_if_enable,
  output wire line_code_select,
  output wire subst_hdb3,
  output wire subst_b8zs,
  output wire codec_active,
  output wire host_bus_style_select,
  output wire [1:0] jitter_atten_position_select,
  output wire chip_select_active,
  output wire serial_access_grant,
  output wire parallel_access_grant
);
  // ---------------------------------------------------------------
  // Pin level filtering
  // ---------------------------------------------------------------
  wire [1:0] mode_lvl;
  wire [1:0] jc_lvl;
  wire [1:0] cb_lvl;

  tri_level_filter #(.SETTLE(SETTLE), .INIT(`TRI_LOW)) mode_filt (
    .sys_clk(sys_clk),
    .reset(reset),
    .level_in(mode_pin_level),
    .level_out(mode_lvl)
  );

  tri_level_filter #(.SETTLE(SETTLE), .INIT(`TRI_MID)) jc_filt (
    .sys_clk(sys_clk),
    .reset(reset),
    .level_in(ja_cs_pin_level),
    .level_out(jc_lvl)
  );

  tri_level_filter #(.SETTLE(SETTLE), .INIT(`TRI_LOW)) cb_filt (
    .sys_clk(sys_clk),
    .reset(reset),
    .level_in({1'h0, code_bus_pin}),
    .level_out(cb_lvl)
  );

  // ---------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------
  function [2:0] mode_of;
    input [1:0] lvl;
    begin
      case (lvl)
        `TRI_LOW: mode_of = `MODE_HW;
        `TRI_HIGH: mode_of = `MODE_PAR;
        `TRI_MID: mode_of = `MODE_SER;
        default: mode_of = `MODE_HW;
      endcase
    end
  endfunction

  function [1:0] ja_of;
    input [1:0] lvl;
    begin
      case (lvl)
        `TRI_LOW: ja_of = `JA_TX;
        `TRI_HIGH: ja_of = `JA_RX;
        `TRI_MID: ja_of = `JA_OFF;
        default: ja_of = `JA_OFF;
      endcase
    end
  endfunction

  // Substitution enables as {hdb3, b8zs}; plain AMI or bipolar data uses neither.
  function [1:0] subst_of;
    input unipolar;
    input code;
    input e1;
    begin
      if (unipolar && (code == `CODE_SUBST)) begin
        subst_of = e1 ? 2'h2 : 2'h1;
      end else begin
        subst_of = 2'h0;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Next-state decode
  // ---------------------------------------------------------------
  reg [2:0] mode_nxt;
  reg code_nxt;
  reg style_nxt;
  reg [1:0] ja_nxt;
  reg cs_nxt;
  reg hw_nxt;
  reg [1:0] subst_nxt;

  always @* begin
    mode_nxt = mode_of(mode_lvl);
    hw_nxt = (mode_nxt == `MODE_HW);
    code_nxt = `CODE_SUBST;
    style_nxt = `BUS_STYLE_SECOND;
    ja_nxt = `JA_OFF;
    cs_nxt = 1'h0;
    if (hw_nxt) begin
      // Chip select and bus style are ignored here.
      code_nxt = cb_lvl[0] ? `CODE_AMI : `CODE_SUBST;
      ja_nxt = ja_of(jc_lvl);
    end else begin
      // In host mode the host bit picks the line code.
      code_nxt = host_code_bit;
      style_nxt = cb_lvl[0] ? `BUS_STYLE_FIRST : `BUS_STYLE_SECOND;
      // A floating select pin does not count as asserted.
      cs_nxt = (jc_lvl == `TRI_LOW);
    end
    subst_nxt = subst_of(unipolar_select, code_nxt, e1_select);
  end

  // ---------------------------------------------------------------
  // Operating mode registers
  // ---------------------------------------------------------------
  reg [2:0] op_mode_r;
  reg parallel_if_enable_r;
  reg serial_if_enable_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      op_mode_r <= `MODE_HW;
      parallel_if_enable_r <= 1'h0;
      serial_if_enable_r <= 1'h0;
    end else begin
      op_mode_r <= mode_nxt;
      parallel_if_enable_r <= (mode_nxt == `MODE_PAR);
      serial_if_enable_r <= (mode_nxt == `MODE_SER);
    end
  end

  // ---------------------------------------------------------------
  // Line code registers
  // ---------------------------------------------------------------
  reg line_code_select_r;
  reg codec_active_r;
  reg subst_hdb3_r;
  reg subst_b8zs_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      line_code_select_r <= `CODE_SUBST;
      codec_active_r <= 1'h0;
      subst_hdb3_r <= 1'h0;
      subst_b8zs_r <= 1'h0;
    end else begin
      line_code_select_r <= code_nxt;
      // The codec only acts on unipolar data.
      codec_active_r <= unipolar_select;
      subst_hdb3_r <= subst_nxt[1];
      subst_b8zs_r <= subst_nxt[0];
    end
  end

  // ---------------------------------------------------------------
  // Host interface and jitter attenuator registers
  // ---------------------------------------------------------------
  reg host_bus_style_select_r;
  reg [1:0] jitter_atten_position_select_r;
  reg chip_select_active_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      host_bus_style_select_r <= `BUS_STYLE_SECOND;
      jitter_atten_position_select_r <= `JA_OFF;
      chip_select_active_r <= 1'h0;
    end else begin
      host_bus_style_select_r <= style_nxt;
      jitter_atten_position_select_r <= ja_nxt;
      chip_select_active_r <= cs_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign op_mode = op_mode_r;
  assign parallel_if_enable = parallel_if_enable_r;
  assign serial_if_enable = serial_if_enable_r;
  assign line_code_select = line_code_select_r;
  assign subst_hdb3 = subst_hdb3_r;
  assign subst_b8zs = subst_b8zs_r;
  assign codec_active = codec_active_r;
  assign host_bus_style_select = host_bus_style_select_r;
  assign jitter_atten_position_select = jitter_atten_position_select_r;
  assign chip_select_active = chip_select_active_r;

  // Accesses pass only while selected and in the matching host mode.
  assign serial_access_grant = serial_access_req & chip_select_active_r &
                               serial_if_enable_r;
  assign parallel_access_grant = parallel_access_req & chip_select_active_r &
                                 parallel_if_enable_r;
endmodule // config_mode_pin_decode

// file: hdl/config_mode_pin_regs.vh
// Encodings and timing counts for the configuration pin decoder.
`ifndef CONFIG_MODE_PIN_REGS_VH
`define CONFIG_MODE_PIN_REGS_VH
// Three-level pin encodings as seen on the pin sense inputs.
`define TRI_LOW 2'h0
`define TRI_HIGH 2'h1
`define TRI_MID 2'h2
// Operating modes (one-hot).
`define MODE_HW 3'h1
`define MODE_PAR 3'h2
`define MODE_SER 3'h4
// Jitter attenuator position (one-hot, zero means disabled).
`define JA_OFF 2'h0
`define JA_TX 2'h1
`define JA_RX 2'h2
// Line code choice: substitution code or plain alternate mark inversion.
`define CODE_SUBST 1'h0
`define CODE_AMI 1'h1
// Host bus style: first family when pin high, second family when low.
`define BUS_STYLE_FIRST 1'h1
`define BUS_STYLE_SECOND 1'h0
// A level is accepted once it has been sampled this many times plus two in a row.
`define SETTLE_COUNT 4'h3
`endif

// file: hdl/tri_level_filter.v
// Debounce filter that accepts a two-bit pin level after it stays stable.
`timescale 1ns/1ps
`include "config_mode_pin_regs.vh"
module tri_level_filter #(
  parameter [3:0] SETTLE = `SETTLE_COUNT,
  parameter [1:0] INIT = `TRI_LOW
) (
  input wire sys_clk,
  input wire reset,
  input wire [1:0] level_in,
  output wire [1:0] level_out
);
  reg [1:0] last_r;
  reg [3:0] count_r;
  reg [1:0] level_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      last_r <= INIT;
      count_r <= 4'h0;
      level_r <= INIT;
    end else if (level_in != last_r) begin
      last_r <= level_in;
      count_r <= 4'h0;
    end else if (count_r < SETTLE) begin
      count_r <= count_r + 4'h1;
    end else begin
      level_r <= last_r;
    end
  end

  assign level_out = level_r;
endmodule // tri_level_filter

// file: bench/strap_model.sv
// Board strap and host select model that drives the decoder pins.
`timescale 1ns/1ps
module strap_model (
  input wire [1:0] mode_w,
  input wire bus_w,
  input wire [1:0] sel_w,
  output wire [1:0] mode_pin_level,
  output wire code_bus_pin,
  output wire [1:0] ja_cs_pin_level
);
  assign mode_pin_level = mode_w;
  assign code_bus_pin = bus_w;
  // The select line follows sel_w directly and can change in the middle of an access.
  assign ja_cs_pin_level = sel_w;
endmodule // strap_model

// file: bench/config_mode_pin_properties.sv
// Checker for the decoded configuration outputs.
`timescale 1ns/1ps
module config_mode_pin_checks (
  input wire sys_clk,
  input wire reset,
  input wire serial_access_req,
  input wire parallel_access_req,
  input wire [2:0] op_mode,
  input wire parallel_if_enable,
  input wire serial_if_enable,
  input wire line_code_select,
  input wire subst_hdb3,
  input wire subst_b8zs,
  input wire host_bus_style_select,
  input wire [1:0] jitter_atten_position_select,
  input wire chip_select_active,
  input wire serial_access_grant,
  input wire parallel_access_grant
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ja_host_off: assert property (op_mode != 3'h1 |->
    jitter_atten_position_select == 2'h0)
    else $error("jitter attenuator placed in host mode");
  a_cs_hw_off: assert property (op_mode == 3'h1 |-> !chip_select_active)
    else $error("chip select active in hardware mode");
  a_bus_hw_off: assert property (op_mode == 3'h1 |-> !host_bus_style_select)
    else $error("bus style set in hardware mode");
  a_par_grant: assert property (parallel_access_grant ==
    (parallel_access_req && chip_select_active && parallel_if_enable))
    else $error("parallel grant mismatch");
  a_ser_grant: assert property (serial_access_grant ==
    (serial_access_req && chip_select_active && serial_if_enable))
    else $error("serial grant mismatch");
  a_mode_enables: assert property ($onehot(op_mode) &&
    parallel_if_enable == (op_mode == 3'h2) && serial_if_enable == (op_mode == 3'h4))
    else $error("mode enables mismatch");
  a_ami_plain: assert property (line_code_select |-> !subst_hdb3 && !subst_b8zs)
    else $error("substitution active with plain code");
  a_subst_one: assert property (!(subst_hdb3 && subst_b8zs))
    else $error("both substitution codes active");
  c_par: cover property (parallel_access_grant);
  c_ser: cover property (serial_access_grant);
  c_ja_rx: cover property (jitter_atten_position_select == 2'h2);
endmodule // config_mode_pin_checks
bind config_mode_pin_decode config_mode_pin_checks i_config_mode_pin_checks (.sys_clk, .reset,
  .serial_access_req, .parallel_access_req, .op_mode, .parallel_if_enable, .serial_if_enable,
  .line_code_select, .subst_hdb3, .subst_b8zs, .host_bus_style_select,
  .jitter_atten_position_select, .chip_select_active, .serial_access_grant,
  .parallel_access_grant);

// file: bench/test_config_mode_pin_decode.sv
// Table-driven bench for the configuration pin decoder.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_config_mode_pin_decode;
  reg sys_clk = 1'h0, reset = 1'h1, e1 = 1'h0, uni = 1'h0, hb = 1'h0, bus_w = 1'h0;
  reg [1:0] mode_w = 2'h0, sel_w = 2'h2;
  wire [1:0] mode_pin, sel_pin, ja;
  wire [2:0] op;
  wire bus_pin, lcs, hdb, b8, bus, cs, sg, pg, pe, se, ca;
  wire [11:0] outs = {op, lcs, hdb, b8, bus, ja, cs, sg, pg};
  int bad_count = 0, n_compared = 0;
  reg [19:0] rows [0:8] = '{20'h06288, 20'h0A250, 20'h36300, 20'h04208, 20'h664A5,
    20'h8B900, 20'hB2860, 20'hEE310, 20'h86886};
  // Free-running reference clock.
  always #4 sys_clk = ~sys_clk;
  strap_model i_strap_model (.mode_w(mode_w), .bus_w(bus_w), .sel_w(sel_w),
    .mode_pin_level(mode_pin), .code_bus_pin(bus_pin), .ja_cs_pin_level(sel_pin));
  config_mode_pin_decode #(.SETTLE(4'h1)) i_config_mode_pin_decode (.sys_clk(sys_clk),
    .reset(reset), .mode_pin_level(mode_pin), .code_bus_pin(bus_pin),
    .ja_cs_pin_level(sel_pin), .e1_select(e1), .unipolar_select(uni), .host_code_bit(hb),
    .serial_access_req(1'h1), .parallel_access_req(1'h1), .op_mode(op),
    .parallel_if_enable(pe), .serial_if_enable(se), .line_code_select(lcs),
    .subst_hdb3(hdb), .subst_b8zs(b8), .codec_active(ca), .host_bus_style_select(bus),
    .jitter_atten_position_select(ja), .chip_select_active(cs),
    .serial_access_grant(sg), .parallel_access_grant(pg));
  task conclude;
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    conclude;
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 1'h0;
    foreach (rows[i]) begin
      {mode_w, bus_w, sel_w, e1, uni, hb} = rows[i][19:12];
      repeat (8) @(negedge sys_clk);
      `CHK(outs, rows[i][11:0])
    end
    // A one-cycle blip on an asserted chip select is filtered out.
    sel_w = 2'h1;
    @(negedge sys_clk);
    sel_w = 2'h0;
    repeat (2) @(negedge sys_clk);
    `CHK(cs, 1'h1)
    repeat (2) @(negedge sys_clk);
    `CHK(sg, 1'h1)
    // A reset in serial host mode returns everything to hardware defaults.
    reset = 1'h1;
    @(negedge sys_clk);
    `CHK({op, lcs, hdb, b8, bus, ja, cs, pe, se, ca}, 13'h0400)
    // After release the straps are taken in again.
    reset = 1'h0;
    repeat (8) @(negedge sys_clk);
    `CHK({outs, pe, se, ca}, 15'h4433)
    conclude;
  end
endmodule // test_config_mode_pin_decode
